// >>> sec_defines.svh
// Offsets, field positions, reset values and timing counts of the serial EEPROM controller
`ifndef SEC_DEFINES_SVH
`define SEC_DEFINES_SVH

`define SEC_OFS_CMD      32'h100000d0
`define SEC_OFS_RDDATA   32'h100000d4
`define SEC_OFS_MAC1     32'h100000d8
`define SEC_OFS_MAC2     32'h100000dc
`define SEC_OFS_MAC3     32'h100000e0

`define SEC_CMD_DATA_MSB 31
`define SEC_CMD_DATA_LSB 16
`define SEC_CMD_OP_MSB   8
`define SEC_CMD_OP_LSB   6
`define SEC_CMD_ADR_MSB  5
`define SEC_BUSY_BIT     31

`define SEC_BUSY_RST     1'b1
`define SEC_REG_RST      32'h00000000
`define SEC_WORD_RST     16'h0000
`define SEC_SIGNATURE    16'ha5a5
`define SEC_AL_LAST      3'h6

`define SEC_OP_READ      3'h6
`define SEC_OP_ERASE     3'h7
`define SEC_OP_WRITE     3'h5
`define SEC_OP_EXT       3'h4
`define SEC_SUB_WR_OFF   2'h0
`define SEC_SUB_WR_ALL   2'h1
`define SEC_SUB_ER_ALL   2'h2
`define SEC_SUB_WR_ON    2'h3

`define SEC_HDR_BITS     5'd10
`define SEC_FULL_BITS    5'd26

`define SEC_RESP_OKAY    2'h0
`define SEC_RESP_SLVERR  2'h2

`define SEC_CLK_NS       100
`define SEC_SK_HALF_NS   400
`define SEC_SK_HALF_CYC  ((`SEC_SK_HALF_NS + `SEC_CLK_NS - 1) / `SEC_CLK_NS)

`endif

// >>> sec_pkg.sv
// Types shared by the serial EEPROM controller
package sec_pkg;

  typedef enum logic [2:0] {
    SEC_ST_IDLE  = 3'h0,
    SEC_ST_SHIFT = 3'h1,
    SEC_ST_GAP   = 3'h3,
    SEC_ST_POLL  = 3'h2,
    SEC_ST_FIN   = 3'h6
  } sec_state_t;

endpackage

// >>> sec_serial_eeprom_controller.sv
// AXI4-Lite serial EEPROM controller with power-up station address load
`timescale 1ns/100ps
`include "sec_defines.svh"

// How it works
// - A command write carries 3-bit opcode and 6-bit address; engine runs it serially.
// - A read command stores the fetched word in bits 15:0 of read data.
// - Busy bit 31 reads 1 during a read, cleared once the word is stored.
// - Busy also reads 1 throughout the power-up load, then drops to 0.
// - Opcodes 110 read, 111 erase, 101 write the addressed single word.
// - Opcode 100: 10xxxx erase all, 01xxxx write all, 00xxxx disable.
// - The power-up load runs exactly once after reset, without software.
// - Load reads word 00H; on signature A5A5H copies words 01H to 06H.
// - Odd words fill bits 15:0, following even words bits 31:16, in turn.
// - Command register is write-only, resets to zero, bits 15:9 ignored.
// - Busy resets to 1; read data and address registers reset to 0.
module sec_serial_eeprom_controller #(
  parameter int SK_HALF = `SEC_SK_HALF_CYC,
  parameter int DEPTH   = 2
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output wire logic        s_axi_wready,
  output wire logic [1:0]  s_axi_bresp,
  output wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output wire logic        s_axi_arready,
  output wire logic [31:0] s_axi_rdata,
  output wire logic [1:0]  s_axi_rresp,
  output wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output wire logic        ee_cs,
  output wire logic        ee_sk,
  output wire logic        ee_sdo,
  input  wire logic        ee_sdi
);
  localparam int PW = $clog2(DEPTH);
  localparam int FW = 25;

  if (SK_HALF < 1 || SK_HALF > 255 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
    $error("sec: unsupported SK_HALF or DEPTH");
  end

  sec_pkg::sec_state_t state_ff;
  logic              sdi_meta_ff;
  logic              sdi_s_ff;
  logic              aw_hold_ff;
  logic              w_hold_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic [31:0]       awaddr_ff;
  logic [31:0]       wdata_ff;
  logic              rvalid_ff;
  logic [1:0]        rresp_ff;
  logic [31:0]       rdata_ff;
  logic [FW-1:0]     fifo_mem [DEPTH];
  logic [PW-1:0]     wptr_ff;
  logic [PW-1:0]     rptr_ff;
  logic [PW:0]       cnt_ff;
  logic [25:0]       sh_ff;
  logic [4:0]        nbits_ff;
  logic [4:0]        bcnt_ff;
  logic [7:0]        ph_ff;
  logic [15:0]       rx_ff;
  logic              sk_ff;
  logic              cs_ff;
  logic              rd_ff;
  logic              poll_ff;
  logic              al_cur_ff;
  logic              al_active_ff;
  logic [2:0]        al_idx_ff;
  logic [31:0]       mac_ff [3];
  logic [15:0]       rd_data_ff;
  logic              busy_ff;

  function automatic logic has_data(input logic [2:0] op, input logic [5:0] adr);
    return op == `SEC_OP_WRITE || (op == `SEC_OP_EXT && adr[5:4] == `SEC_SUB_WR_ALL);
  endfunction

  function automatic logic needs_poll(input logic [2:0] op, input logic [5:0] adr);
    return op == `SEC_OP_WRITE || op == `SEC_OP_ERASE ||
           (op == `SEC_OP_EXT && (adr[5:4] == `SEC_SUB_ER_ALL || adr[5:4] == `SEC_SUB_WR_ALL));
  endfunction

  // Serial input synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sdi_meta_ff <= 1'b0;
      sdi_s_ff    <= 1'b0;
    end else begin
      sdi_meta_ff <= ee_sdi;
      sdi_s_ff    <= sdi_meta_ff;
    end
  end

  // AXI write channel
  logic fifo_ready;
  logic is_cmd;
  logic wr_map;
  logic wr_go;
  logic push;
  assign fifo_ready    = cnt_ff != (PW + 1)'(DEPTH);
  assign is_cmd        = awaddr_ff == `SEC_OFS_CMD;
  assign wr_map        = is_cmd || awaddr_ff == `SEC_OFS_RDDATA || awaddr_ff == `SEC_OFS_MAC1 ||
                         awaddr_ff == `SEC_OFS_MAC2 || awaddr_ff == `SEC_OFS_MAC3;
  assign wr_go         = aw_hold_ff && w_hold_ff && !bvalid_ff && (!is_cmd || fifo_ready);
  assign push          = wr_go && is_cmd;
  assign s_axi_awready = !aw_hold_ff;
  assign s_axi_wready  = !w_hold_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awaddr_ff  <= `SEC_REG_RST;
      wdata_ff   <= `SEC_REG_RST;
    end else begin
      if (wr_go) begin
        aw_hold_ff <= 1'b0;
      end else if (s_axi_awvalid && !aw_hold_ff) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (wr_go) begin
        w_hold_ff <= 1'b0;
      end else if (s_axi_wvalid && !w_hold_ff) begin
        w_hold_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `SEC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_map ? `SEC_RESP_OKAY : `SEC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // AXI read channel
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= `SEC_RESP_OKAY;
      rdata_ff  <= `SEC_REG_RST;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= `SEC_RESP_OKAY;
      unique case (s_axi_araddr)
        `SEC_OFS_CMD:    rdata_ff <= `SEC_REG_RST;
        `SEC_OFS_RDDATA: rdata_ff <= {busy_ff, 15'h0000, rd_data_ff};
        `SEC_OFS_MAC1:   rdata_ff <= mac_ff[0];
        `SEC_OFS_MAC2:   rdata_ff <= mac_ff[1];
        `SEC_OFS_MAC3:   rdata_ff <= mac_ff[2];
        default: begin
          rdata_ff <= `SEC_REG_RST;
          rresp_ff <= `SEC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Two-entry command buffer; bits 15:9 dropped
  logic start_al;
  logic pop;
  logic [2:0]  sel_op;
  logic [5:0]  sel_adr;
  logic [15:0] sel_dat;
  assign start_al = state_ff == sec_pkg::SEC_ST_IDLE && al_active_ff;
  assign pop      = state_ff == sec_pkg::SEC_ST_IDLE && !al_active_ff && cnt_ff != '0;
  assign sel_op   = start_al ? `SEC_OP_READ : fifo_mem[rptr_ff][8:6];
  assign sel_adr  = start_al ? {3'h0, al_idx_ff} : fifo_mem[rptr_ff][5:0];
  assign sel_dat  = start_al ? `SEC_WORD_RST : fifo_mem[rptr_ff][24:9];

  always_ff @(posedge aclk) begin
    if (push) begin
      fifo_mem[wptr_ff] <= {wdata_ff[`SEC_CMD_DATA_MSB:`SEC_CMD_DATA_LSB],
                            wdata_ff[`SEC_CMD_OP_MSB:0]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff  <= '0;
    end else begin
      wptr_ff <= wptr_ff + PW'(push);
      rptr_ff <= rptr_ff + PW'(pop);
      cnt_ff  <= cnt_ff + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end

  // Serial engine
  logic tick;
  assign tick   = ph_ff == 8'(SK_HALF - 1);
  assign ee_cs  = cs_ff;
  assign ee_sk  = sk_ff;
  assign ee_sdo = sh_ff[25];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff  <= sec_pkg::SEC_ST_IDLE;
      sh_ff     <= '0;
      nbits_ff  <= `SEC_HDR_BITS;
      bcnt_ff   <= '0;
      ph_ff     <= '0;
      rx_ff     <= `SEC_WORD_RST;
      sk_ff     <= 1'b0;
      cs_ff     <= 1'b0;
      rd_ff     <= 1'b0;
      poll_ff   <= 1'b0;
      al_cur_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        sec_pkg::SEC_ST_IDLE: begin
          if (start_al || pop) begin
            sh_ff     <= {1'b1, sel_op, sel_adr,
                          sel_op == `SEC_OP_READ ? `SEC_WORD_RST : sel_dat};
            nbits_ff  <= (has_data(sel_op, sel_adr) || sel_op == `SEC_OP_READ) ?
                         `SEC_FULL_BITS : `SEC_HDR_BITS;
            rd_ff     <= sel_op == `SEC_OP_READ;
            poll_ff   <= needs_poll(sel_op, sel_adr);
            al_cur_ff <= start_al;
            bcnt_ff   <= '0;
            ph_ff     <= '0;
            cs_ff     <= 1'b1;
            state_ff  <= sec_pkg::SEC_ST_SHIFT;
          end
        end
        sec_pkg::SEC_ST_SHIFT: begin
          ph_ff <= tick ? 8'h00 : ph_ff + 8'h01;
          if (tick && !sk_ff) begin
            sk_ff <= 1'b1;
          end else if (tick) begin
            sk_ff <= 1'b0;
            if (rd_ff && bcnt_ff >= `SEC_HDR_BITS) begin
              rx_ff <= {rx_ff[14:0], sdi_s_ff};
            end
            if (bcnt_ff == nbits_ff - 5'd1) begin
              cs_ff    <= 1'b0;
              state_ff <= poll_ff ? sec_pkg::SEC_ST_GAP : sec_pkg::SEC_ST_FIN;
            end else begin
              bcnt_ff <= bcnt_ff + 5'd1;
              sh_ff   <= {sh_ff[24:0], 1'b0};
            end
          end
        end
        sec_pkg::SEC_ST_GAP: begin
          ph_ff <= tick ? 8'h00 : ph_ff + 8'h01;
          if (tick) begin
            cs_ff    <= 1'b1;
            state_ff <= sec_pkg::SEC_ST_POLL;
          end
        end
        sec_pkg::SEC_ST_POLL: begin
          // Synchroniser still holds samples taken before select rose
          if (ph_ff != 8'h02) begin
            ph_ff <= ph_ff + 8'h01;
          end else if (sdi_s_ff) begin
            cs_ff    <= 1'b0;
            state_ff <= sec_pkg::SEC_ST_FIN;
          end
        end
        sec_pkg::SEC_ST_FIN: begin
          state_ff <= sec_pkg::SEC_ST_IDLE;
        end
        default: begin
          cs_ff    <= 1'b0;
          sk_ff    <= 1'b0;
          state_ff <= sec_pkg::SEC_ST_IDLE;
        end
      endcase
    end
  end

  // Power-up load of the station address registers
  logic       fin;
  logic [1:0] widx;
  assign fin  = state_ff == sec_pkg::SEC_ST_FIN;
  assign widx = 2'((al_idx_ff - 3'h1) >> 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      al_active_ff <= 1'b1;
      al_idx_ff    <= 3'h0;
      mac_ff[0]    <= `SEC_REG_RST;
      mac_ff[1]    <= `SEC_REG_RST;
      mac_ff[2]    <= `SEC_REG_RST;
    end else if (fin && al_cur_ff) begin
      if (al_idx_ff == 3'h0) begin
        if (rx_ff != `SEC_SIGNATURE) begin
          al_active_ff <= 1'b0;
          mac_ff[0]    <= `SEC_REG_RST;
          mac_ff[1]    <= `SEC_REG_RST;
          mac_ff[2]    <= `SEC_REG_RST;
        end else begin
          al_idx_ff <= 3'h1;
        end
      end else begin
        if (al_idx_ff[0]) begin
          mac_ff[widx][15:0] <= rx_ff;
        end else begin
          mac_ff[widx][31:16] <= rx_ff;
        end
        if (al_idx_ff == `SEC_AL_LAST) begin
          al_active_ff <= 1'b0;
        end else begin
          al_idx_ff <= al_idx_ff + 3'h1;
        end
      end
    end
  end

  // Read data and busy flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_data_ff <= `SEC_WORD_RST;
    end else if (fin && rd_ff && !al_cur_ff) begin
      rd_data_ff <= rx_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_ff <= `SEC_BUSY_RST;
    end else begin
      busy_ff <= push || al_active_ff || state_ff != sec_pkg::SEC_ST_IDLE ||
                 cnt_ff != '0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_busy_on_push: assert property (push |=> busy_ff)
    else $error("busy not set after command");
  a_busy_autoload: assert property (al_active_ff |=> busy_ff)
    else $error("busy low during power-up load");
  a_read_store: assert property (fin && rd_ff && !al_cur_ff |=> rd_data_ff == $past(rx_ff))
    else $error("read word not stored");
  a_load_once: assert property (!al_active_ff |=> !al_active_ff)
    else $error("power-up load restarted");
  a_sig_miss: assert property (fin && al_cur_ff && al_idx_ff == 3'h0 && rx_ff != `SEC_SIGNATURE
                               |=> !al_active_ff && mac_ff[0] == '0 && mac_ff[2] == '0)
    else $error("signature miss not handled");
  a_mac_low: assert property (fin && al_cur_ff && al_idx_ff == 3'h1
                              |=> mac_ff[0][15:0] == $past(rx_ff))
    else $error("first word misplaced");
  a_mac_top: assert property (fin && al_cur_ff && al_idx_ff == 3'h6
                              |=> mac_ff[2][31:16] == $past(rx_ff) && !al_active_ff)
    else $error("last word misplaced");
  a_start_bit: assert property (state_ff == sec_pkg::SEC_ST_IDLE ##1
                                state_ff == sec_pkg::SEC_ST_SHIFT |-> ee_sdo && ee_cs)
    else $error("frame does not open with start bit");
  a_read_len: assert property (state_ff == sec_pkg::SEC_ST_SHIFT && rd_ff
                               |-> nbits_ff == `SEC_FULL_BITS && !poll_ff)
    else $error("read frame length wrong");
  a_poll_end: assert property (state_ff == sec_pkg::SEC_ST_POLL && ph_ff == 8'h02 && sdi_s_ff
                               |=> fin ##1 state_ff == sec_pkg::SEC_ST_IDLE)
    else $error("ready not honoured");
  a_poll_busy: assert property (state_ff == sec_pkg::SEC_ST_POLL |=> busy_ff)
    else $error("busy low while programming");

  c_user_read: cover property (fin && rd_ff && !al_cur_ff);
  c_load_done: cover property (fin && al_cur_ff && al_idx_ff == 3'h6);
  c_prog_poll: cover property (state_ff == sec_pkg::SEC_ST_POLL ##1 fin);
  c_fifo_full: cover property (!fifo_ready && aw_hold_ff && w_hold_ff && is_cmd);

endmodule // sec_serial_eeprom_controller

// >>> sec_eeprom_model.sv
// Behavioural serial EEPROM partner: 64 words of 16 bits
`timescale 1ns/100ps
module sec_eeprom_model #(
  parameter int PROG_NS = 30000
) (
  input  wire logic ee_cs,
  input  wire logic ee_sk,
  input  wire logic ee_sdo,
  output var  logic ee_sdi
);
  logic [15:0] mem [64];
  logic [25:0] sh;
  logic [2:0]  op;
  logic [5:0]  ad;
  logic        wen;
  logic        pend;
  logic        prog;
  int          n;

  initial begin
    ee_sdi = 1'b0;
    wen    = 1'b0;
    pend   = 1'b0;
    prog   = 1'b0;
    n      = 0;
    sh     = 26'h0;
    op     = 3'h0;
    ad     = 6'h00;
    for (int k = 0; k < 64; k++) begin
      mem[k] = 16'hc000 | 16'(k * 16'h0111);
    end
    mem[0] = 16'ha5a5;
  end

  // New frame; ready status while a programming cycle is pending, else the line level is inverted
  always @(posedge ee_cs) begin
    n = 0;
    ee_sdi = pend ? !prog : !ee_sdi;
  end

  always @(posedge ee_sk) begin
    if (ee_cs) begin
      sh = {sh[24:0], ee_sdo};
      n = n + 1;
      if (n == 10) begin
        op = (sh[9] === 1'b1) ? sh[8:6] : 3'h0;
        ad = sh[5:0];
        if (op == 3'h4 && ad[5:4] == 2'h3) wen = 1'b1;
        if (op == 3'h4 && ad[5:4] == 2'h0) wen = 1'b0;
        if (op == 3'h6) ee_sdi = mem[ad][15];
      end
    end
  end

  // Read data moves on at the falling clock edge, most significant bit first
  always @(negedge ee_sk) begin
    if (ee_cs && op == 3'h6 && n >= 11 && n <= 25) ee_sdi = mem[ad][25-n];
  end

  // Programming starts when select drops after a write or erase frame
  always @(negedge ee_cs) begin
    if (pend && n == 0) begin
      pend = 1'b0;
    end else if ((n == 26 && (op == 3'h5 || (op == 3'h4 && ad[5:4] == 2'h1)))
                 || (n == 10 && (op == 3'h7 || (op == 3'h4 && ad[5:4] == 2'h2)))) begin
      for (int k = 0; k < 64; k++) begin
        if (wen && (op == 3'h4 || k == ad)) mem[k] = (n == 26) ? sh[15:0] : 16'hffff;
      end
      pend = 1'b1;
      prog = wen;
    end
    ee_sdi = !ee_sdi;
  end

  always begin
    @(posedge prog);
    #(PROG_NS);
    prog = 1'b0;
    if (ee_cs) ee_sdi = 1'b1;
  end
endmodule // sec_eeprom_model

// >>> sec_serial_eeprom_controller_tb.sv
// Self-checking testbench of the serial EEPROM controller
`timescale 1ns/100ps
`include "sec_defines.svh"
module sec_serial_eeprom_controller_tb;
  `define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
    $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end

  logic        aclk;
  logic        aresetn;
  logic [31:0] s_axi_awaddr;
  logic        s_axi_awvalid;
  logic [31:0] s_axi_wdata;
  logic        s_axi_wvalid;
  logic        s_axi_bready;
  logic [31:0] s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_rready;
  wire         s_axi_awready;
  wire         s_axi_wready;
  wire  [1:0]  s_axi_bresp;
  wire         s_axi_bvalid;
  wire         s_axi_arready;
  wire  [31:0] s_axi_rdata;
  wire  [1:0]  s_axi_rresp;
  wire         s_axi_rvalid;
  wire         ee_cs;
  wire         ee_sk;
  wire         ee_sdo;
  logic        ee_sdi;
  int          err_count;
  int          checks_done;
  int          cyc;
  logic [31:0] rd;
  logic [1:0]  rs;
  logic [15:0] w;

  sec_serial_eeprom_controller DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ee_cs(ee_cs), .ee_sk(ee_sk), .ee_sdo(ee_sdo),
    .ee_sdi(ee_sdi)
  );

  sec_eeprom_model eeprom (.ee_cs(ee_cs), .ee_sk(ee_sk), .ee_sdo(ee_sdo), .ee_sdi(ee_sdi));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = !aclk;
  end

  task automatic stop_test;
    begin
      if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      stop_test();
    end
  end

  // Handshakes are judged mid-cycle, acted on at the following rising edge
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic da, dw, ta, tw, tb;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      da = 1'b0;
      dw = 1'b0;
      while (!(da && dw)) begin
        @(negedge aclk);
        ta = !da && s_axi_awready;
        tw = !dw && s_axi_wready;
        @(posedge aclk);
        if (ta) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
        da = da | ta;
        dw = dw | tw;
      end
      do begin
        @(negedge aclk);
        tb = s_axi_bvalid;
        r = s_axi_bresp;
        @(posedge aclk);
      end while (!tb);
      s_axi_bready <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic t;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(negedge aclk);
        t = s_axi_arready;
        @(posedge aclk);
      end while (!t);
      s_axi_arvalid <= 1'b0;
      do begin
        @(negedge aclk);
        t = s_axi_rvalid;
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk);
      end while (!t);
      s_axi_rready <= 1'b0;
    end
  endtask

  task automatic cmd(input logic [2:0] op, input logic [5:0] ad, input logic [15:0] d);
    logic [1:0] r;
    begin
      axi_wr(`SEC_OFS_CMD, {d, 7'h00, op, ad}, r);
      `CHK("command response", `SEC_RESP_OKAY, r)
    end
  endtask

  task automatic poll;
    begin
      axi_rd(`SEC_OFS_RDDATA, rd, rs);
      while (rd[31] !== 1'b0) axi_rd(`SEC_OFS_RDDATA, rd, rs);
    end
  endtask

  task automatic rd_word(input logic [5:0] ad, output logic [15:0] v);
    begin
      cmd(`SEC_OP_READ, ad, 16'h0000);
      poll();
      v = rd[15:0];
    end
  endtask

  task automatic chk_mac(input logic [95:0] e);
    begin
      for (int i = 0; i < 3; i++) begin
        axi_rd(`SEC_OFS_MAC1 + 32'(4 * i), rd, rs);
        `CHK("station address", e[32*i +: 32], rd)
      end
    end
  endtask

  function automatic logic [15:0] ew(input int k);
    return 16'hc000 | 16'(k * 16'h0111);
  endfunction

  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 32'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 32'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    err_count = 0;
    checks_done = 0;
    cyc = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`SEC_OFS_RDDATA, rd, rs);
    `CHK("status after reset", 32'h80000000, rd)
    axi_rd(`SEC_OFS_MAC2, rd, rs);
    `CHK("address after reset", 32'h00000000, rd)
    axi_rd(`SEC_OFS_CMD, rd, rs);
    `CHK("command readback", 32'h00000000, rd)
    poll();
    chk_mac({ew(6), ew(5), ew(4), ew(3), ew(2), ew(1)});
    axi_rd(32'h100000e4, rd, rs);
    `CHK("unmapped response", `SEC_RESP_SLVERR, rs)
    `CHK("unmapped data", 32'h00000000, rd)
    axi_wr(`SEC_OFS_MAC1, 32'hffffffff, rs);
    `CHK("read-only write response", `SEC_RESP_OKAY, rs)
    axi_rd(`SEC_OFS_MAC1, rd, rs);
    `CHK("read-only kept", {ew(2), ew(1)}, rd)
    // Read with reserved bits and data field set
    axi_wr(`SEC_OFS_CMD, {16'hdead, 7'h7f, `SEC_OP_READ, 6'h03}, rs);
    axi_rd(`SEC_OFS_RDDATA, rd, rs);
    `CHK("busy during read", 1'b1, rd[31])
    poll();
    `CHK("read word", {16'h0000, ew(3)}, rd)
    cmd(`SEC_OP_EXT, 6'h30, 16'h0000);
    cmd(`SEC_OP_WRITE, 6'h10, 16'h1234);
    cmd(`SEC_OP_READ, 6'h10, 16'h0000);
    poll();
    `CHK("written word", 16'h1234, rd[15:0])
    cmd(`SEC_OP_ERASE, 6'h10, 16'h0000);
    repeat (200) @(posedge aclk);
    axi_rd(`SEC_OFS_RDDATA, rd, rs);
    `CHK("busy while erasing", 1'b1, rd[31])
    rd_word(6'h10, w);
    `CHK("erased word", 16'hffff, w)
    cmd(`SEC_OP_EXT, 6'h15, 16'h5a5a);
    rd_word(6'h3f, w);
    `CHK("write all top", 16'h5a5a, w)
    rd_word(6'h00, w);
    `CHK("write all bottom", 16'h5a5a, w)
    cmd(`SEC_OP_EXT, 6'h2a, 16'h0000);
    rd_word(6'h3f, w);
    `CHK("erase all", 16'hffff, w)
    cmd(`SEC_OP_EXT, 6'h0c, 16'h0000);
    cmd(`SEC_OP_WRITE, 6'h01, 16'h0000);
    rd_word(6'h01, w);
    `CHK("write while disabled", 16'hffff, w)
    // Signature now gone: second reset must load zeros
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`SEC_OFS_RDDATA, rd, rs);
    `CHK("status after second reset", 32'h80000000, rd)
    poll();
    chk_mac(96'h0);
    stop_test();
  end
endmodule // sec_serial_eeprom_controller_tb
